/* File: lci_engine.sv */
// lci_engine: instruction interpreter of a 16x2 character display controller.
// assumes host pins are asynchronous to i_sys_clk and a scan engine reads cells.
// Summary of operation
// - clear fills display ram with space, zeroes address counter, cursor to top-left.
// - clear also forces entry direction to increment.
// - home zeroes address counter and cancels display shift, ram untouched.
// - entry mode stores direction; address counter steps up or down per access.
// - glyph ram accesses step the address counter the same way.
// - auto shift moves display only on display ram writes, by direction bit.
// - display control stores display-on; off blanks screen, keeps ram.
// - cursor bit shows or hides cursor without touching entry direction.
// - blink alternates cursor cell between all dots and stored character.
// - shift command moves cursor or display left or right per bit pair.
// - display shift leaves the address counter unchanged.
// - two-line cursor movement wraps line one end to line two start.
// - display shift rotates every line together within its own range.
// - unshifted screen maps line one to 00-0F, line two from 40.
// - function set latches bus width, line count and font bits.
// - glyph address command loads six bits and selects glyph ram.
// - display address command loads seven bits and selects display ram.
// - status read gives busy flag on bit 7 and address counter below.
// - data write stores byte into selected ram at address counter.
// - data read returns selected ram byte at address counter.
// - select high means data path, low instruction; rw high means read.
// - narrow bus moves each byte as two nibbles on upper lines.
// - busy held high while executing; host waits for it low.
module lci_engine #(
	parameter int LONG_CYC = lci_pkg::LONG_EXEC_CYC,
	parameter int SHORT_CYC = lci_pkg::SHORT_EXEC_CYC,
	parameter int BLINK_CYC = lci_pkg::BLINK_HALF_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_reg_select,
	input wire logic i_rw,
	input wire logic i_enable,
	input wire logic [7:0] i_db,
	output logic [7:0] o_db,
	output logic o_db_oe_n,
	output logic o_busy_flag,
	output logic o_display_on,
	output logic o_cursor_on,
	output logic o_blink_on,
	output logic o_two_line,
	output logic o_font_5x11,
	output logic o_bus_width_sel,
	output logic [6:0] o_addr_counter,
	input wire logic i_scan_line,
	input wire logic [3:0] i_scan_col,
	output logic [7:0] o_scan_char,
	output logic o_scan_solid,
	output logic o_scan_cursor
);
	// ==========================================================
	// elaboration checks: the 128-cell clear walk must fit in the long busy time
	if (LONG_CYC <= 128 || SHORT_CYC < 1 || BLINK_CYC < 1) begin : g_bad_timing
		$error("lci_engine: timing parameters out of range");
	end
	// ==========================================================
	// pin synchronisers
	logic en_s1, en_s2, en_s3, sel_s1, sel_s2, rw_s1, rw_s2;
	logic [7:0] db_s1, db_s2;
	always_ff @(posedge i_sys_clk) begin
		en_s1 <= i_enable;
		en_s2 <= en_s1;
		en_s3 <= en_s2;
		sel_s1 <= i_reg_select;
		sel_s2 <= sel_s1;
		rw_s1 <= i_rw;
		rw_s2 <= rw_s1;
		db_s1 <= i_db;
		db_s2 <= db_s1;
	end
	// enable edges seen past the synchroniser
	wire en_rise = en_s2 & ~en_s3;
	wire en_fall = en_s3 & ~en_s2;
	// ==========================================================
	// control state
	lci_pkg::lci_state_t state, next_state;
	logic [7:0] lat_db;
	logic [3:0] hi_nib;
	logic [6:0] addr_counter, shift_off, clear_idx;
	logic [31:0] busy_cnt, blink_cnt;
	logic lat_sel, lat_rw, nib_phase, busy_flag, sel_glyph, blink_phase;
	logic entry_inc, auto_display_shift;
	logic display_on, cursor_on, blink_on;
	logic bus_width_sel, two_line, font_5x11;
	// ==========================================================
	// byte assembly and transfer decode
	wire [7:0] wr_byte = bus_width_sel ? lat_db : {hi_nib, lat_db[7:4]};
	wire commit = en_fall & (bus_width_sel | nib_phase);
	wire idle = (state == lci_pkg::ST_IDLE);
	wire do_instr = commit & ~lat_sel & ~lat_rw & idle;
	wire do_wdata = commit & lat_sel & ~lat_rw & idle;
	wire do_rdata = commit & lat_sel & lat_rw & idle;
	// highest set bit picks the command
	wire is_daddr = wr_byte[7];
	wire is_gaddr = (wr_byte[7:6] == 2'b01);
	wire is_func = (wr_byte[7:5] == 3'b001);
	wire is_shift = (wr_byte[7:4] == 4'b0001);
	wire is_disp = (wr_byte[7:3] == 5'b00001);
	wire is_entry = (wr_byte[7:2] == 6'b000001);
	wire is_home = (wr_byte[7:1] == 7'b0000001);
	wire is_clear = (wr_byte == 8'h01);
	// ==========================================================
	// address counter stepping with line wrap
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
			input logic glyph, input logic two);
		logic [6:0] r;
		r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
		if (glyph) begin
			r[6] = 1'b0;
		end else if (two) begin
			if (up && a == lci_pkg::LINE1_LAST_2) r = lci_pkg::LINE2_BASE;
			else if (up && a == lci_pkg::LINE2_LAST_2) r = lci_pkg::ADDR_ZERO;
			else if (!up && a == lci_pkg::LINE2_BASE) r = lci_pkg::LINE1_LAST_2;
			else if (!up && a == lci_pkg::ADDR_ZERO) r = lci_pkg::LINE2_LAST_2;
		end else begin
			if (up && a == lci_pkg::LAST_1) r = lci_pkg::ADDR_ZERO;
			else if (!up && a == lci_pkg::ADDR_ZERO) r = lci_pkg::LAST_1;
		end
		return r;
	endfunction : step_addr

	wire [6:0] ring_len = two_line ? lci_pkg::LINE_LEN_2 : lci_pkg::LINE_LEN_1;
	wire [6:0] off_left = (shift_off == 7'(ring_len - 7'h01)) ? lci_pkg::ADDR_ZERO
		: 7'(shift_off + 7'h01);
	wire [6:0] off_right = (shift_off == lci_pkg::ADDR_ZERO) ? 7'(ring_len - 7'h01)
		: 7'(shift_off - 7'h01);

	// ==========================================================
	// ram and its port selection
	logic [7:0] disp_data, glyph_data, scan_data;
	wire clearing = (state == lci_pkg::ST_CLEAR);
	wire we_disp = clearing | (do_wdata & ~sel_glyph);
	wire we_glyph = do_wdata & sel_glyph;
	wire [6:0] waddr = clearing ? clear_idx : addr_counter;
	wire [7:0] wdata = clearing ? lci_pkg::SPACE_CODE : wr_byte;
	wire [6:0] scan_pos_raw = 7'({3'b000, i_scan_col} + shift_off);
	wire [6:0] scan_pos = (scan_pos_raw >= ring_len) ? 7'(scan_pos_raw - ring_len)
		: scan_pos_raw;
	wire [6:0] scan_addr = (i_scan_line & two_line) ? 7'(lci_pkg::LINE2_BASE + scan_pos)
		: scan_pos;
	wire at_cursor = ~sel_glyph & (scan_addr == addr_counter);

	lci_ram u_ram (
		.i_sys_clk(i_sys_clk),
		.i_we_disp(we_disp),
		.i_we_glyph(we_glyph),
		.i_waddr(waddr),
		.i_wdata(wdata),
		.i_raddr(addr_counter),
		.i_scan_addr(scan_addr),
		.o_disp_data(disp_data),
		.o_glyph_data(glyph_data),
		.o_scan_data(scan_data)
	);

	// read byte: ram on data path, busy and counter on instruction path
	wire [7:0] ram_byte = sel_glyph ? glyph_data : disp_data;
	wire [7:0] rd_byte = sel_s2 ? ram_byte : {busy_flag, addr_counter};
	wire [7:0] rd_out = bus_width_sel ? rd_byte
		: (nib_phase ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
	// ==========================================================
	// sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			lci_pkg::ST_IDLE: begin
				if (do_instr && is_clear) next_state = lci_pkg::ST_CLEAR;
				else if (do_instr || do_wdata || do_rdata) next_state = lci_pkg::ST_EXEC;
			end
			lci_pkg::ST_CLEAR: begin
				if (clear_idx == lci_pkg::CLEAR_LAST) next_state = lci_pkg::ST_EXEC;
			end
			lci_pkg::ST_EXEC: begin
				if (busy_cnt <= 32'd1) next_state = lci_pkg::ST_IDLE;
			end
		endcase
	end

	// state, busy timer and clear walker
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= lci_pkg::ST_IDLE;
			busy_cnt <= '0;
			clear_idx <= lci_pkg::ADDR_ZERO;
		end else begin
			state <= next_state;
			clear_idx <= clearing ? 7'(clear_idx + 7'h01) : lci_pkg::ADDR_ZERO;
			if (do_instr)
				busy_cnt <= (is_clear | is_home) ? 32'(LONG_CYC) : 32'(SHORT_CYC);
			else if (do_wdata | do_rdata)
				busy_cnt <= 32'(SHORT_CYC);
			else if (busy_cnt != 32'd0)
				busy_cnt <= busy_cnt - 32'd1;
		end
	end
	// busy flag follows the sequencer
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) busy_flag <= 1'b0;
		else busy_flag <= (next_state != lci_pkg::ST_IDLE);
	end

	// ==========================================================
	// host bus latch and nibble pairing
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			lat_db <= lci_pkg::NIBBLE_ZERO;
			lat_sel <= 1'b0;
			lat_rw <= 1'b0;
			hi_nib <= 4'h0;
			nib_phase <= 1'b0;
		end else begin
			if (en_s2) begin
				lat_db <= db_s2;
				lat_sel <= sel_s2;
				lat_rw <= rw_s2;
			end
			if (en_fall && !bus_width_sel) begin
				nib_phase <= ~nib_phase;
				if (!nib_phase) hi_nib <= lat_db[7:4];
			end else if (bus_width_sel) begin
				nib_phase <= 1'b0;
			end
		end
	end
	// read drive: data valid from enable rise, released on enable low
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_db <= lci_pkg::NIBBLE_ZERO;
			o_db_oe_n <= 1'b1;
		end else begin
			if (en_rise && rw_s2) o_db <= rd_out;
			o_db_oe_n <= ~(en_s2 & rw_s2);
		end
	end

	// ==========================================================
	// address counter, ram select and shift offset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			addr_counter <= lci_pkg::ADDR_ZERO;
			sel_glyph <= 1'b0;
			shift_off <= lci_pkg::ADDR_ZERO;
		end else if (do_wdata || do_rdata) begin
			addr_counter <= step_addr(addr_counter, entry_inc, sel_glyph, two_line);
			if (do_wdata && auto_display_shift && !sel_glyph)
				shift_off <= entry_inc ? off_left : off_right;
		end else if (do_instr) begin
			if (is_daddr) begin
				addr_counter <= wr_byte[6:0];
				sel_glyph <= 1'b0;
			end else if (is_gaddr) begin
				addr_counter <= {1'b0, wr_byte[5:0]};
				sel_glyph <= 1'b1;
			end else if (is_shift) begin
				if (wr_byte[lci_pkg::B_SC])
					shift_off <= wr_byte[lci_pkg::B_RL] ? off_right : off_left;
				else
					addr_counter <= step_addr(addr_counter, wr_byte[lci_pkg::B_RL],
						sel_glyph, two_line);
			end else if (is_home || is_clear) begin
				addr_counter <= lci_pkg::ADDR_ZERO;
				sel_glyph <= 1'b0;
				shift_off <= lci_pkg::ADDR_ZERO;
			end
		end
	end

	// mode bits
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			entry_inc <= 1'b1;
			auto_display_shift <= 1'b0;
			display_on <= 1'b0;
			cursor_on <= 1'b0;
			blink_on <= 1'b0;
			bus_width_sel <= 1'b1;
			two_line <= 1'b0;
			font_5x11 <= 1'b0;
		end else if (do_instr) begin
			if (is_clear) entry_inc <= 1'b1;
			if (is_entry) begin
				entry_inc <= wr_byte[lci_pkg::B_ID];
				auto_display_shift <= wr_byte[lci_pkg::B_AUTO_SHIFT];
			end
			if (is_disp) begin
				display_on <= wr_byte[lci_pkg::B_DISP];
				cursor_on <= wr_byte[lci_pkg::B_CURS];
				blink_on <= wr_byte[lci_pkg::B_BLNK];
			end
			if (is_func) begin
				bus_width_sel <= wr_byte[lci_pkg::B_BUS_WIDTH];
				two_line <= wr_byte[lci_pkg::B_N];
				font_5x11 <= wr_byte[lci_pkg::B_F];
			end
		end
	end

	// ==========================================================
	// blink timebase
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !blink_on) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
		end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
			blink_cnt <= '0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 32'd1;
		end
	end

	// scan outputs: blank when off, solid cell on blink phase
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_scan_char <= lci_pkg::SPACE_CODE;
			o_scan_solid <= 1'b0;
			o_scan_cursor <= 1'b0;
		end else begin
			o_scan_char <= display_on ? scan_data : lci_pkg::SPACE_CODE;
			o_scan_solid <= display_on & blink_on & blink_phase & at_cursor;
			o_scan_cursor <= display_on & cursor_on & at_cursor;
		end
	end
	// ==========================================================
	// status outputs straight from the mode, busy and address counter flops
	assign o_busy_flag = busy_flag;
	assign o_display_on = display_on;
	assign o_cursor_on = cursor_on;
	assign o_blink_on = blink_on;
	assign o_two_line = two_line;
	assign o_font_5x11 = font_5x11;
	assign o_bus_width_sel = bus_width_sel;
	assign o_addr_counter = addr_counter;
endmodule : lci_engine

/* File: lci_pkg.sv */
// lci_pkg: constants shared by the character display instruction engine.
// assumes a single 10 MHz system clock driving every user of these names.
package lci_pkg;

	// ==========================================================
	// clock and execution timing
	localparam int CLK_KHZ = 10000;
	localparam int LONG_EXEC_NS = 1520000; // clear and home
	localparam int SHORT_EXEC_NS = 38000; // every other timed access
	localparam int LONG_EXEC_CYC = (LONG_EXEC_NS * (CLK_KHZ / 1000) + 999) / 1000;
	localparam int SHORT_EXEC_CYC = (SHORT_EXEC_NS * (CLK_KHZ / 1000) + 999) / 1000;
	localparam int BLINK_HALF_CYC = 4096000;

	// ==========================================================
	// address map of the display ram
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [6:0] LINE_LEN_2 = 7'h28; // 40 cells per line, two-line mode
	localparam logic [6:0] LINE_LEN_1 = 7'h50; // 80 cells, one-line mode
	localparam logic [6:0] LINE1_LAST_2 = 7'h27;
	localparam logic [6:0] LINE2_LAST_2 = 7'h67;
	localparam logic [6:0] LAST_1 = 7'h4f;
	localparam logic [6:0] ADDR_ZERO = 7'h00;
	localparam logic [6:0] CLEAR_LAST = 7'h7f;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] NIBBLE_ZERO = 8'h00;

	// ==========================================================
	// instruction field positions
	localparam int B_ID = 1; // entry mode: direction
	localparam int B_AUTO_SHIFT = 0; // entry mode: auto display shift
	localparam int B_DISP = 2;
	localparam int B_CURS = 1;
	localparam int B_BLNK = 0;
	localparam int B_SC = 3; // shift: display versus cursor
	localparam int B_RL = 2; // shift: right versus left
	localparam int B_BUS_WIDTH = 4; // function set: bus width
	localparam int B_N = 3; // function set: line count
	localparam int B_F = 2; // function set: font

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_CLEAR = 3'b100
	} lci_state_t;

endpackage : lci_pkg

/* File: lci_ram.sv */
// lci_ram: display ram and glyph ram storage with one write port.
// assumes writes arrive on the system clock; reads are combinational.
module lci_ram (
	input wire logic i_sys_clk,
	input wire logic i_we_disp,
	input wire logic i_we_glyph,
	input wire logic [6:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [6:0] i_raddr,
	input wire logic [6:0] i_scan_addr,
	output logic [7:0] o_disp_data,
	output logic [7:0] o_glyph_data,
	output logic [7:0] o_scan_data
);

	// ==========================================================
	// storage
	logic [7:0] display_ram [128];
	logic [7:0] glyph_ram [64];

	// write port
	always_ff @(posedge i_sys_clk) begin
		if (i_we_disp) begin
			display_ram[i_waddr] <= i_wdata;
		end
		if (i_we_glyph) begin
			glyph_ram[i_waddr[5:0]] <= i_wdata;
		end
	end

	// read ports
	assign o_disp_data = display_ram[i_raddr];
	assign o_glyph_data = glyph_ram[i_raddr[5:0]];
	assign o_scan_data = display_ram[i_scan_addr];

endmodule : lci_ram

/* File: lci_engine_props.sv */
// lci_engine_props: port-level assertions for the instruction engine.
// assumes LONG_CYC and SHORT_CYC match the instance; one clock, sync reset.
module lci_engine_props #(
	parameter int LONG_CYC = 200,
	parameter int SHORT_CYC = 5
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_reg_select,
	input wire logic i_rw,
	input wire logic i_enable,
	input wire logic [7:0] o_db,
	input wire logic o_db_oe_n,
	input wire logic o_busy_flag,
	input wire logic o_display_on,
	input wire logic o_cursor_on,
	input wire logic o_blink_on,
	input wire logic o_two_line,
	input wire logic o_font_5x11,
	input wire logic o_bus_width_sel,
	input wire logic [6:0] o_addr_counter,
	input wire logic [7:0] o_scan_char,
	input wire logic o_scan_solid,
	input wire logic o_scan_cursor
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// busy length counter
	int unsigned busy_len;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !o_busy_flag) busy_len <= 0;
		else busy_len <= busy_len + 1;
	end
	wire logic [5:0] mode_bits = {o_display_on, o_cursor_on, o_blink_on, o_two_line,
		o_font_5x11, o_bus_width_sel};
	// status read start in 8-bit mode
	sequence s_stat_rd;
		$fell(o_db_oe_n) ##0 (!i_reg_select && o_bus_width_sel);
	endsequence
	// ==========================================================
	// assertions
	AST_RST_VALUES: assert property (disable iff (1'b0) i_rst |=> !o_busy_flag && o_db_oe_n &&
		o_addr_counter == 7'h00 && o_bus_width_sel && !o_display_on)
		else $error("reset values wrong");
	AST_BUSY_LEN: assert property ($fell(o_busy_flag) |->
		(busy_len >= SHORT_CYC - 1 && busy_len <= SHORT_CYC + 1) ||
		(busy_len >= LONG_CYC - 1 && busy_len <= LONG_CYC + 1))
		else $error("busy length wrong");
	AST_BUSY_MAX: assert property (o_busy_flag |-> busy_len <= LONG_CYC + 1)
		else $error("busy too long");
	AST_OE_READ: assert property (!o_db_oe_n |-> $past(i_rw, 2))
		else $error("data driven on write");
	AST_OE_IDLE: assert property (!i_enable [*5] |-> o_db_oe_n)
		else $error("data driven with enable low");
	AST_STATUS: assert property (s_stat_rd |-> o_db[6:0] == o_addr_counter)
		else $error("status byte wrong");
	AST_ADDR_CAUSE: assert property (!$stable(o_addr_counter) |=> o_busy_flag)
		else $error("address moved without operation");
	AST_MODE_CAUSE: assert property (!$stable(mode_bits) |=> o_busy_flag)
		else $error("mode moved without command");
	AST_SCAN_OFF: assert property (!o_display_on && !$past(o_display_on) |->
		o_scan_char == lci_pkg::SPACE_CODE)
		else $error("blank screen shows data");
	AST_SOLID: assert property (o_scan_solid |-> $past(o_blink_on))
		else $error("solid cell without blink");
	AST_CURSOR: assert property (o_scan_cursor |-> $past(o_cursor_on))
		else $error("cursor shown while hidden");
endmodule : lci_engine_props

bind lci_engine lci_engine_props #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_props (
	.i_sys_clk, .i_rst, .i_reg_select, .i_rw, .i_enable, .o_db, .o_db_oe_n, .o_busy_flag,
	.o_display_on, .o_cursor_on, .o_blink_on, .o_two_line, .o_font_5x11, .o_bus_width_sel,
	.o_addr_counter, .o_scan_char, .o_scan_solid, .o_scan_cursor);

/* File: lci_host.sv */
// lci_host: host processor model on the parallel display bus.
// assumes the bench resolves the data bus from both sides' drivers.
module lci_host (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_db,
	output logic o_reg_select = 1'b0,
	output logic o_rw = 1'b0,
	output logic o_enable = 1'b0,
	output logic [7:0] o_db = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	logic narrow = 1'b0; // set by the bench in 4-bit mode
	int poll_fail = 0; // polls that never saw busy low
	// ==========================================================
	// one enable pulse, request held until commit
	task automatic xfer(input logic sel, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_sys_clk);
		o_reg_select <= sel;
		o_rw <= rw;
		o_db <= d;
		o_enable <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		q = i_db;
		o_enable <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		o_db <= ~d; // released lines lose the old value
		repeat (2) @(posedge i_sys_clk);
	endtask : xfer
	// whole byte, split in two nibbles on the upper lines when narrow
	task automatic put(input logic sel, input logic rw, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] a;
		logic [7:0] b;
		if (narrow) begin
			xfer(sel, rw, {d[7:4], 4'h5}, a);
			xfer(sel, rw, {d[3:0], 4'ha}, b);
			q = {a[7:4], b[7:4]};
		end else begin
			xfer(sel, rw, d, q);
		end
	endtask : put
	// poll the status until idle
	task automatic wait_idle();
		logic [7:0] s;
		int n;
		n = 0;
		do begin
			put(1'b0, 1'b1, 8'h00, s);
			n++;
		end while (s[7] !== 1'b0 && n < 100);
		if (s[7] !== 1'b0) poll_fail++;
	endtask : wait_idle
	task automatic wr(input logic sel, input logic [7:0] d);
		logic [7:0] q;
		put(sel, 1'b0, d, q);
		wait_idle();
	endtask : wr
	task automatic rd(output logic [7:0] q);
		put(1'b1, 1'b1, 8'h00, q);
		wait_idle();
	endtask : rd
endmodule : lci_host

/* File: lci_engine_bench.sv */
// lci_engine_bench: self-checking bench of the instruction engine.
// assumes short busy and blink parameters; host model drives the pins.
module lci_engine_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sl = 1'b0;
	logic [3:0] sc = 4'h0;
	logic reg_sel, rw, en, busy, disp, curs, blink, two, font, bw, oe_n, solid, cur_cell;
	logic [7:0] h_db, d_db, ch, q;
	logic [6:0] addr;
	int mismatches = 0;
	int cmp_count = 0;
	// resolved data bus
	wire logic [7:0] db_bus = oe_n ? h_db : d_db;
	always #50 clk = ~clk;
	lci_host u_host (.i_sys_clk(clk), .i_db(db_bus), .o_reg_select(reg_sel), .o_rw(rw),
		.o_enable(en), .o_db(h_db));
	lci_engine #(.LONG_CYC(200), .SHORT_CYC(5), .BLINK_CYC(4)) u_dut (
		.i_sys_clk(clk), .i_rst(rst), .i_reg_select(reg_sel), .i_rw(rw), .i_enable(en),
		.i_db(db_bus), .o_db(d_db), .o_db_oe_n(oe_n), .o_busy_flag(busy),
		.o_display_on(disp), .o_cursor_on(curs), .o_blink_on(blink), .o_two_line(two),
		.o_font_5x11(font), .o_bus_width_sel(bw), .o_addr_counter(addr),
		.i_scan_line(sl), .i_scan_col(sc), .o_scan_char(ch), .o_scan_solid(solid),
		.o_scan_cursor(cur_cell));
	// ==========================================================
	// compare and closing
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic scan(input logic l, input logic [3:0] c, input logic [7:0] e);
		@(posedge clk);
		sl <= l;
		sc <= c;
		repeat (3) @(posedge clk);
		chk(ch, e);
	endtask : scan
	// ==========================================================
	// scenarios
	task automatic t_clear();
		chk({4'h0, bw, two, font, disp}, 8'h08);
		u_host.wr(0, 8'h04);
		u_host.wr(0, 8'h01);
		chk({1'b0, addr}, 8'h00);
		u_host.rd(q);
		chk(q, 8'h20);
		chk({1'b0, addr}, 8'h01);
		chk({7'h0, oe_n}, 8'h01);
		u_host.wr(0, 8'hcf);
		u_host.wr(1, 8'h20);
		chk({1'b0, addr}, 8'h00);
	endtask : t_clear
	task automatic t_modes();
		u_host.wr(0, 8'h3c);
		chk({4'h0, bw, two, font, disp}, 8'h0e);
		u_host.wr(0, 8'h38);
		u_host.wr(0, 8'h0f);
		chk({5'h0, disp, curs, blink}, 8'h07);
		u_host.wr(0, 8'h0c);
		chk({5'h0, disp, curs, blink}, 8'h04);
	endtask : t_modes
	task automatic t_ram();
		u_host.wr(0, 8'ha7);
		u_host.wr(1, 8'h41);
		chk({1'b0, addr}, 8'h40);
		u_host.wr(0, 8'ha7);
		u_host.rd(q);
		chk(q, 8'h41);
		u_host.wr(0, 8'h04);
		u_host.wr(0, 8'hc0);
		u_host.wr(1, 8'h42);
		chk({1'b0, addr}, 8'h27);
		u_host.wr(0, 8'h06);
		u_host.wr(0, 8'h7f);
		chk({1'b0, addr}, 8'h3f);
		u_host.wr(1, 8'h15);
		chk({1'b0, addr}, 8'h00);
		u_host.wr(0, 8'h7f);
		u_host.rd(q);
		chk(q, 8'h15);
		u_host.wr(0, 8'hbf);
		u_host.rd(q);
		chk(q, 8'h20);
	endtask : t_ram
	task automatic t_shift();
		u_host.wr(0, 8'h85);
		u_host.wr(0, 8'h10);
		chk({1'b0, addr}, 8'h04);
		u_host.wr(0, 8'h14);
		u_host.wr(0, 8'h18);
		u_host.wr(0, 8'h1c);
		chk({1'b0, addr}, 8'h05);
		u_host.wr(0, 8'hc2);
		u_host.wr(1, 8'h5a);
		scan(1, 4'h2, 8'h5a);
		u_host.wr(0, 8'h07);
		u_host.wr(0, 8'h80);
		u_host.wr(1, 8'h33);
		scan(1, 4'h1, 8'h5a);
		u_host.put(0, 0, 8'h02, q);
		u_host.put(0, 1, 8'h00, q);
		chk(q, 8'h80);
		chk({7'h0, busy}, 8'h01);
		u_host.wait_idle();
		scan(1, 4'h2, 8'h5a);
		u_host.rd(q);
		chk(q, 8'h33);
		u_host.wr(0, 8'h06);
		u_host.wr(0, 8'h08);
		scan(1, 4'h2, 8'h20);
		u_host.wr(0, 8'h0c);
		scan(1, 4'h2, 8'h5a);
	endtask : t_shift
	task automatic t_blink();
		logic seen_on;
		logic seen_off;
		seen_on = 1'b0;
		seen_off = 1'b0;
		u_host.wr(0, 8'h0f);
		scan(0, 4'h1, 8'h20);
		repeat (12) begin
			@(posedge clk);
			seen_on |= (solid === 1'b1);
			seen_off |= (solid === 1'b0);
		end
		chk({6'h0, seen_on, seen_off}, 8'h03);
		chk({7'h0, cur_cell}, 8'h01);
	endtask : t_blink
	task automatic t_narrow();
		u_host.put(0, 0, 8'h28, q);
		u_host.narrow = 1'b1; // the block pairs nibbles from the next transfer on
		u_host.wait_idle();
		chk({7'h0, bw}, 8'h00);
		u_host.wr(0, 8'hc5);
		u_host.wr(1, 8'ha9);
		chk({1'b0, addr}, 8'h46);
		u_host.wr(0, 8'hc5);
		u_host.rd(q);
		chk(q, 8'ha9);
		u_host.wr(0, 8'h38);
		u_host.narrow = 1'b0;
		chk({7'h0, bw}, 8'h01);
	endtask : t_narrow
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_clear();
		t_modes();
		t_ram();
		t_shift();
		t_blink();
		t_narrow();
		chk(8'(u_host.poll_fail), 8'h00);
		end_sim();
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		end_sim();
	end
endmodule : lci_engine_bench
